// ---- verilog/setting_group_selector.sv ----
// Operation
// - Eight groups, exactly one active; code enables at most seven, group eight never
// - Reset: only group one, selector idle
// - Two or more enabled: requests decide
// - Requests accepted as pulse or level
// - Priority falls with group number
// - Two held requests: higher wins
// - Pulsed group holds until another request
// - Held group one blocks all others
// - Held two to seven block lower groups
// - Held group eight blocks nothing
// - Override ignores inputs, operator selects group
// - Forced field none or one-eight, resets none
// - Forced select is pulse, persists after release
// - Override enable resets off, gates operator changes
// - Release with held requests: inputs regain control
// - Used-groups count, newly enabled load defaults
// - Remote select blocked by held higher group
// - Status reads active group, one after reset
// - Filtered timestamped events on status changes
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "group_sel_consts.svh"
module setting_group_selector (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic group_one,
	input wire logic group_two,
	input wire logic group_three,
	input wire logic group_four,
	input wire logic group_five,
	input wire logic group_six,
	input wire logic group_seven,
	input wire logic group_eight,
	output logic [2:0] active_group,
	output logic [7:0] group_enabled,
	output logic [7:0] load_defaults,
	output logic event_valid,
	output logic [4:0] event_id,
	output logic event_on,
	output logic [31:0] event_stamp
);

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b+:8] = d[8*b+:8];
			end
		end
		return r;
	endfunction

	// Groups one up to code+1 are in use
	function automatic logic [7:0] used_mask(input logic [2:0] code);
		return 8'((9'h002 << code) - 9'h001);
	endfunction

	group_sel_pkg::wr_state_t wr_q;
	group_sel_pkg::rd_state_t rd_q;
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic wr_ok;
	logic rd_take;
	logic rd_ok;
	logic [31:0] rd_word;

	logic [2:0] used_q;
	logic force_en_q;
	logic force_en_prev_q;
	logic [3:0] force_sel_q;
	logic [3:0] remote_sel_q;
	logic [31:0] evt_on_q;
	logic [31:0] evt_off_q;
	logic [2:0] active_q;
	logic [7:0] enabled_q;
	logic [7:0] defaults_q;
	logic [7:0] req_prev_q;
	logic fail_unconf_q;
	logic fail_force_q;
	logic fail_lower_q;

	logic [7:0] req_level;
	logic [7:0] req_rise;
	logic [7:0] enabled;
	logic multi;
	logic force_fall;
	logic force_wr;
	logic remote_wr;
	logic [3:0] sel_code;
	logic [2:0] sel_idx;
	logic sel_blocked;
	logic op_valid;
	logic op_unconf;
	logic op_force_fail;
	logic op_lower;
	logic take_valid;
	logic [2:0] take_index;
	logic arb_unconf;
	logic arb_lower;
	logic level_valid;
	logic [2:0] level_index;
	logic [31:0] watch;
	logic [31:0] now_stamp;

	// Write channel: address and data taken in either order
	assign s_axi_awready = (wr_q == group_sel_pkg::WR_IDLE) && !aw_have_q;
	assign s_axi_wready = (wr_q == group_sel_pkg::WR_IDLE) && !w_have_q;
	assign s_axi_bvalid = (wr_q == group_sel_pkg::WR_RESP);
	assign wr_fire = (wr_q == group_sel_pkg::WR_IDLE) && aw_have_q && w_have_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_comb begin
		if (aw_addr_q == `OFF_USED) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == `OFF_FORCE_EN) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == `OFF_FORCE_SEL) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == `OFF_REMOTE_SEL) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == `OFF_EVT_ON) begin
			wr_ok = 1'b1;
		end else if (aw_addr_q == `OFF_EVT_OFF) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q <= group_sel_pkg::WR_IDLE;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			case (wr_q)
				group_sel_pkg::WR_IDLE: begin
					if (wr_fire) begin
						wr_q <= group_sel_pkg::WR_RESP;
						s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				default: begin
					if (s_axi_bready) begin
						wr_q <= group_sel_pkg::WR_IDLE;
					end
				end
			endcase
		end
	end

	// Read channel, one cycle to data
	assign s_axi_arready = (rd_q == group_sel_pkg::RD_IDLE);
	assign s_axi_rvalid = (rd_q == group_sel_pkg::RD_DATA);
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == `OFF_USED) begin
			rd_word = {29'h0, used_q};
		end else if (s_axi_araddr == `OFF_FORCE_EN) begin
			rd_word = {31'h0, force_en_q};
		end else if (s_axi_araddr == `OFF_FORCE_SEL) begin
			rd_word = {28'h0, force_sel_q};
		end else if (s_axi_araddr == `OFF_REMOTE_SEL) begin
			rd_word = {28'h0, remote_sel_q};
		end else if (s_axi_araddr == `OFF_STATUS) begin
			rd_word = {12'h0, req_level, enabled_q, 1'b0, active_q};
		end else if (s_axi_araddr == `OFF_EVT_ON) begin
			rd_word = evt_on_q;
		end else if (s_axi_araddr == `OFF_EVT_OFF) begin
			rd_word = evt_off_q;
		end else if (s_axi_araddr == `OFF_STAMP) begin
			rd_word = now_stamp;
		end else begin
			rd_word = 32'h0000_0000;
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= group_sel_pkg::RD_IDLE;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			case (rd_q)
				group_sel_pkg::RD_IDLE: begin
					if (rd_take) begin
						rd_q <= group_sel_pkg::RD_DATA;
						s_axi_rdata <= rd_word;
						s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
					end
				end
				default: begin
					if (s_axi_rready) begin
						rd_q <= group_sel_pkg::RD_IDLE;
					end
				end
			endcase
		end
	end

	// Settings; out-of-range codes leave the field unchanged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			used_q <= `RST_USED;
		end else if (wr_fire && aw_addr_q == `OFF_USED && w_strb_q[0]) begin
			if (w_data_q[2:0] <= `USED_MAX) begin
				used_q <= w_data_q[2:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_en_q <= 1'b0;
			force_en_prev_q <= 1'b0;
		end else begin
			force_en_prev_q <= force_en_q;
			if (wr_fire && aw_addr_q == `OFF_FORCE_EN && w_strb_q[0]) begin
				force_en_q <= w_data_q[0];
			end
		end
	end

	assign force_wr = wr_fire && aw_addr_q == `OFF_FORCE_SEL && w_strb_q[0]
		&& w_data_q[3:0] <= `SEL_MAX && w_data_q[7:4] == 4'h0;
	assign remote_wr = wr_fire && aw_addr_q == `OFF_REMOTE_SEL && w_strb_q[0]
		&& w_data_q[3:0] <= `SEL_MAX && w_data_q[7:4] == 4'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_sel_q <= `RST_SEL;
			remote_sel_q <= `RST_SEL;
		end else begin
			if (force_wr) begin
				force_sel_q <= w_data_q[3:0];
			end
			if (remote_wr) begin
				remote_sel_q <= w_data_q[3:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_on_q <= `RST_EVT_EN;
			evt_off_q <= `RST_EVT_EN;
		end else if (wr_fire) begin
			if (aw_addr_q == `OFF_EVT_ON) begin
				evt_on_q <= merge(evt_on_q, w_data_q, w_strb_q);
			end
			if (aw_addr_q == `OFF_EVT_OFF) begin
				evt_off_q <= merge(evt_off_q, w_data_q, w_strb_q);
			end
		end
	end

	// Request inputs
	assign req_level = {group_eight, group_seven, group_six, group_five,
		group_four, group_three, group_two, group_one};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_prev_q <= 8'h00;
		end else begin
			req_prev_q <= req_level;
		end
	end

	assign req_rise = req_level & ~req_prev_q;
	assign enabled = used_mask(used_q);
	assign multi = (used_q != `RST_USED);
	assign force_fall = force_en_prev_q && !force_en_q;

	group_request_arbiter #(
		.N(8)
	) u_arb (
		.req_level(req_level),
		.req_rise(req_rise),
		.enabled(enabled),
		.take_valid(take_valid),
		.take_index(take_index),
		.fail_unconf(arb_unconf),
		.fail_lower(arb_lower),
		.level_valid(level_valid),
		.level_index(level_index)
	);

	// Operator selection: forced field or remote field, written this cycle
	always_comb begin
		sel_code = force_wr ? w_data_q[3:0] : remote_sel_q;
		if (remote_wr) begin
			sel_code = w_data_q[3:0];
		end
		sel_idx = 3'(sel_code - 4'h1);
		sel_blocked = remote_wr && ((req_level & 8'((9'h001 << sel_idx) - 9'h001)) != 8'h00);
		op_valid = 1'b0;
		op_unconf = 1'b0;
		op_force_fail = 1'b0;
		op_lower = 1'b0;
		if ((force_wr || remote_wr) && sel_code != `SEL_NONE) begin
			if (!force_en_q) begin
				op_force_fail = 1'b1;
			end else if (!enabled[sel_idx]) begin
				op_unconf = 1'b1;
			end else if (sel_blocked) begin
				op_lower = 1'b1;
			end else begin
				op_valid = 1'b1;
			end
		end
	end

	// Exactly one group is active, held as an index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_q <= `RST_ACTIVE;
		end else if (!multi || !enabled[active_q]) begin
			active_q <= `RST_ACTIVE;
		end else if (force_en_q) begin
			if (op_valid) begin
				active_q <= sel_idx;
			end
		end else if (force_fall && level_valid) begin
			active_q <= level_index;
		end else if (take_valid) begin
			active_q <= take_index;
		end
	end

	// Registered mask, so a new group loads defaults for one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enabled_q <= 8'h01;
			defaults_q <= 8'h00;
		end else begin
			enabled_q <= enabled;
			defaults_q <= enabled & ~enabled_q;
		end
	end

	// Failure flags stand one cycle each
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_unconf_q <= 1'b0;
			fail_force_q <= 1'b0;
			fail_lower_q <= 1'b0;
		end else begin
			fail_unconf_q <= op_unconf || (multi && !force_en_q && arb_unconf);
			fail_force_q <= op_force_fail;
			fail_lower_q <= op_lower || (multi && !force_en_q && arb_lower);
		end
	end

	always_comb begin
		watch = 32'h0000_0000;
		watch[`EV_ENABLED_LSB+:8] = enabled_q;
		watch[`EV_REQ_LSB+:8] = req_level;
		watch[`EV_ACTIVE_LSB+:8] = 8'(9'h001 << active_q);
		watch[`EV_FORCE_EN] = force_en_q;
		watch[`EV_REMOTE] = (remote_sel_q != `SEL_NONE);
		watch[`EV_FAIL_UNCONF] = fail_unconf_q;
		watch[`EV_FAIL_FORCE] = fail_force_q;
		watch[`EV_FAIL_LOWER] = fail_lower_q;
	end

	// One event per cycle; simultaneous changes queue as pending bits
	event_reporter #(
		.W(32)
	) u_evt (
		.aclk(aclk),
		.aresetn(aresetn),
		.watch(watch),
		.on_en(evt_on_q),
		.off_en(evt_off_q),
		.event_valid(event_valid),
		.event_id(event_id),
		.event_on(event_on),
		.event_stamp(event_stamp),
		.now_stamp(now_stamp)
	);

	assign active_group = active_q;
	assign group_enabled = enabled_q;
	assign load_defaults = defaults_q;

endmodule

// ---- verilog/group_sel_consts.svh ----
`ifndef GROUP_SEL_CONSTS_SVH
`define GROUP_SEL_CONSTS_SVH

// Register byte offsets
`define OFF_USED 8'h00
`define OFF_FORCE_EN 8'h04
`define OFF_FORCE_SEL 8'h08
`define OFF_REMOTE_SEL 8'h0c
`define OFF_STATUS 8'h10
`define OFF_EVT_ON 8'h14
`define OFF_EVT_OFF 8'h18
`define OFF_STAMP 8'h1c

// Field limits and positions
`define USED_MAX 3'h6
`define SEL_NONE 4'h0
`define SEL_MAX 4'h8
`define ST_ENABLED_LSB 4
`define ST_REQ_LSB 12

// Event vector positions
`define EV_ENABLED_LSB 0
`define EV_REQ_LSB 8
`define EV_ACTIVE_LSB 16
`define EV_FORCE_EN 24
`define EV_REMOTE 25
`define EV_FAIL_UNCONF 26
`define EV_FAIL_FORCE 27
`define EV_FAIL_LOWER 28

// Reset values
`define RST_USED 3'h0
`define RST_SEL 4'h0
`define RST_ACTIVE 3'h0
`define RST_EVT_EN 32'hffff_ffff

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/group_sel_pkg.sv ----
package group_sel_pkg;

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_DATA = 1'b1
	} rd_state_t;

endpackage

// ---- verilog/group_request_arbiter.sv ----
`timescale 1ns/1ps
module group_request_arbiter #(
	parameter int N = 8
) (
	input wire logic [N-1:0] req_level,
	input wire logic [N-1:0] req_rise,
	input wire logic [N-1:0] enabled,
	output logic take_valid,
	output logic [2:0] take_index,
	output logic fail_unconf,
	output logic fail_lower,
	output logic level_valid,
	output logic [2:0] level_index
);

	generate
		if (N < 2 || N > 8) begin : g_bad
			$error("group_request_arbiter: N must be 2 to 8");
		end
	endgenerate

	// Lowest index wins
	function automatic logic [3:0] first_set(input logic [N-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	logic [N-1:0] blocked;
	logic [N-1:0] cand;
	logic [3:0] cand_pick;
	logic [3:0] lvl_pick;

	// A held request shuts out every lower-priority one
	generate
		for (genvar g = 0; g < N; g++) begin : g_block
			if (g == 0) begin : g_top
				assign blocked[g] = 1'b0;
			end else begin : g_low
				assign blocked[g] = |req_level[g-1:0];
			end
		end
	endgenerate

	assign cand = req_rise & ~blocked;
	assign cand_pick = first_set(cand);
	assign take_valid = cand_pick[3] && enabled[cand_pick[2:0]];
	assign take_index = cand_pick[2:0];
	assign fail_unconf = cand_pick[3] && !enabled[cand_pick[2:0]];
	assign fail_lower = |(req_rise & blocked);

	assign lvl_pick = first_set(req_level);
	assign level_valid = lvl_pick[3] && enabled[lvl_pick[2:0]];
	assign level_index = lvl_pick[2:0];

endmodule

// ---- verilog/event_reporter.sv ----
`timescale 1ns/1ps
module event_reporter #(
	parameter int W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] watch,
	input wire logic [W-1:0] on_en,
	input wire logic [W-1:0] off_en,
	output logic event_valid,
	output logic [4:0] event_id,
	output logic event_on,
	output logic [31:0] event_stamp,
	output logic [31:0] now_stamp
);

	generate
		if (W < 1 || W > 32) begin : g_bad
			$error("event_reporter: W must be 1 to 32");
		end
	endgenerate

	logic [W-1:0] prev_q;
	logic [W-1:0] pend_q;
	logic [W-1:0] pol_q;
	logic [W-1:0] chg;
	logic [W-1:0] clr;
	logic [31:0] time_q;
	logic pick_valid;
	logic [4:0] pick_id;

	// Edge filter per direction
	assign chg = (watch ^ prev_q) & ((watch & on_en) | (~watch & off_en));

	always_comb begin
		pick_valid = 1'b0;
		pick_id = 5'h00;
		clr = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				pick_valid = 1'b1;
				pick_id = 5'(i);
			end
		end
		if (pick_valid) begin
			clr[pick_id] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= watch;
		end
	end

	// A new change wins over the clear of the one being sent
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= '0;
			pol_q <= '0;
		end else begin
			pend_q <= (pend_q & ~clr) | chg;
			pol_q <= (pol_q & ~chg) | (watch & chg);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			time_q <= 32'h0000_0000;
		end else begin
			time_q <= time_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_valid <= 1'b0;
			event_id <= 5'h00;
			event_on <= 1'b0;
			event_stamp <= 32'h0000_0000;
		end else begin
			event_valid <= pick_valid;
			event_id <= pick_id;
			event_on <= pol_q[pick_id];
			event_stamp <= time_q;
		end
	end

	assign now_stamp = time_q;

endmodule

// ---- verification/group_req_source.sv ----
`timescale 1ns/1ps
module group_req_source (
	input wire logic aclk,
	input wire logic [7:0] req_cmd,
	output logic [7:0] req_out
);
	// Registered so request edges never race the selector's sampling edge
	always_ff @(posedge aclk) begin
		req_out <= req_cmd;
	end
endmodule

// ---- verification/group_sel_monitor.sv ----
`timescale 1ns/1ps
module group_sel_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic group_one,
	input wire logic group_two,
	input wire logic group_three,
	input wire logic group_five,
	input wire logic group_eight,
	input wire logic [2:0] active_group,
	input wire logic [7:0] group_enabled,
	input wire logic [7:0] load_defaults,
	input wire logic event_valid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	group_mask_ok_a: assert property (group_enabled[0] && !group_enabled[7])
		else $error("group enable mask out of range");
	reset_values_a: assert property ($rose(aresetn) |->
		active_group == 3'h0 && group_enabled == 8'h01) else $error("bad reset state");
	active_enabled_a: assert property (group_enabled[active_group])
		else $error("disabled group left active");
	one_blocks_all_a: assert property (group_one && $rose(group_three) |->
		##1 (active_group != 3'h2) [*2]) else $error("held group one not blocking");
	mid_blocks_lower_a: assert property (group_two && $rose(group_five) |->
		##1 (active_group != 3'h4) [*2]) else $error("held group two not blocking");
	pulse_take_a: assert property ($rose(group_two) && !group_one && group_enabled[1] |->
		##2 active_group == 3'h1) else $error("pulse on group two not taken");
	eight_free_a: assert property (group_eight && $rose(group_three) && !group_one &&
		!group_two && group_enabled[2] |-> ##2 active_group == 3'h2)
		else $error("held group eight blocked a request");
	load_pulse_a: assert property (|load_defaults |=> load_defaults == 8'h00)
		else $error("load defaults longer than one cycle");
	event_follow_a: assert property ($changed(active_group) |-> ##[2:40] event_valid)
		else $error("no event after group change");
	cover property ($rose(group_two) && !group_one ##2 active_group == 3'h1);
	cover property (group_one && $rose(group_three));
	cover property (|load_defaults);
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "group_sel_consts.svh"
module tb_top;
	logic aclk, aresetn, event_valid, event_on;
	logic [4:0] event_id;
	logic [7:0] s_axi_awaddr, s_axi_araddr, req_cmd, req, group_enabled, load_defaults;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, event_stamp, st;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [2:0] active_group;
	int err_total, n_checks, cyc;
	group_req_source src (.aclk, .req_cmd, .req_out(req));
	setting_group_selector DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .group_one(req[0]), .group_two(req[1]),
		.group_three(req[2]), .group_four(req[3]), .group_five(req[4]), .group_six(req[5]),
		.group_seven(req[6]), .group_eight(req[7]), .active_group, .group_enabled,
		.load_defaults, .event_valid, .event_id, .event_on, .event_stamp);
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_grp(input logic [2:0] e);
		chk("active_group", {29'h0, e}, {29'h0, active_group});
	endtask
	task automatic chk_evt(input logic [4:0] id);
		chk("event_valid", 32'h1, {31'h0, event_valid});
		chk("event_id", {27'h0, id}, {27'h0, event_id});
		chk("event_on", 32'h1, {31'h0, event_on});
	endtask
	task automatic test_end(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task automatic req_set(input logic [7:0] v, input int n);
		req_cmd <= v;
		repeat (n) @(posedge aclk);
	endtask
	// Held levels rise first, so the pulse meets a standing level
	task automatic pulse(input logic [7:0] h, input logic [7:0] p);
		req_set(h, 2);
		req_set(h | p, 2);
		req_set(h, 4);
	endtask
	function automatic logic [2:0] pick(input logic [7:0] v, input logic [7:0] en,
		input logic [2:0] cur);
		pick = cur;
		for (int i = 7; i >= 0; i--) if (v[i] && en[i]) pick = 3'(i);
	endfunction
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 10000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		logic [7:0] ra [6], hh [6], pp [6], v;
		logic [31:0] rv [6];
		logic [2:0] ee [6], e;
		err_total = 0;
		n_checks = 0;
		cyc = 0;
		aresetn = 1'b0;
		req_cmd = 8'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		ra = '{`OFF_USED, `OFF_FORCE_EN, `OFF_FORCE_SEL, `OFF_REMOTE_SEL, `OFF_EVT_ON, `OFF_EVT_OFF};
		rv = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_ffff, 32'hffff_ffff};
		hh = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h80, 8'h00};
		pp = '{8'h04, 8'h10, 8'h10, 8'h01, 8'h04, 8'h28};
		ee = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h2, 3'h3};
		void'($urandom(22722));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_grp(3'h0);
		rd_reg(`OFF_STATUS);
		chk("status", 32'h10, rd);
		for (int i = 0; i < 6; i++) begin
			rd_reg(ra[i]);
			chk("reset value", rv[i], rd);
		end
		rd_reg(8'h20);
		chk("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, rs});
		wr(8'h24, 32'h1);
		chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, rs});
		test_end("reset");
		pulse(8'h00, 8'h02);
		chk_grp(3'h0);
		wr(`OFF_USED, 32'h6);
		@(posedge aclk);
		chk("group_enabled", 32'h7f, {24'h0, group_enabled});
		chk("load_defaults", 32'h7e, {24'h0, load_defaults});
		wr(`OFF_USED, 32'h7);
		rd_reg(`OFF_USED);
		chk("used", 32'h6, rd);
		e = 3'h0;
		for (int g = 0; g < 8; g++) begin
			v = 8'h01 << g;
			pulse(8'h00, v);
			e = pick(v, 8'h7f, e);
			chk_grp(e);
		end
		for (int i = 0; i < 6; i++) begin
			pulse(hh[i], pp[i]);
			chk_grp(ee[i]);
		end
		test_end("requests");
		req_set(8'h04, 6);
		wr(`OFF_FORCE_SEL, 32'h5);
		chk_grp(3'h2);
		wr(`OFF_FORCE_EN, 32'h1);
		wr(`OFF_FORCE_SEL, 32'h5);
		chk_grp(3'h4);
		pulse(8'h04, 8'h01);
		chk_grp(3'h4);
		wr(`OFF_REMOTE_SEL, 32'h6);
		chk_grp(3'h4);
		wr(`OFF_FORCE_SEL, 32'h9);
		rd_reg(`OFF_FORCE_SEL);
		chk("force_sel", 32'h5, rd);
		wr(`OFF_FORCE_EN, 32'h0);
		repeat (2) @(posedge aclk);
		chk_grp(3'h2);
		req_set(8'h00, 4);
		wr(`OFF_FORCE_EN, 32'h1);
		wr(`OFF_FORCE_SEL, 32'h6);
		chk_grp(3'h5);
		wr(`OFF_REMOTE_SEL, 32'h7);
		chk_grp(3'h6);
		wr(`OFF_FORCE_EN, 32'h0);
		repeat (4) @(posedge aclk);
		chk_grp(3'h6);
		rd_reg(`OFF_STATUS);
		chk("status", 32'h7f6, rd);
		test_end("override");
		e = 3'h6;
		for (int k = 0; k < 40; k++) begin
			v = 8'($urandom());
			if (k == 0) v = 8'h80;
			if (k == 1) v = 8'hff;
			req_set(v, 15);
			e = pick(v, 8'h7f, e);
			chk_grp(e);
			req_set(8'h00, 15);
		end
		test_end("random");
		pulse(8'h00, 8'h40);
		chk_grp(3'h6);
		wr(`OFF_USED, 32'h1);
		@(posedge aclk);
		chk_grp(3'h0);
		chk("group_enabled", 32'h3, {24'h0, group_enabled});
		test_end("shrink");
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_grp(3'h0);
		chk("group_enabled", 32'h1, {24'h0, group_enabled});
		repeat (2) @(posedge aclk);
		chk_evt(5'h00);
		st = event_stamp;
		@(posedge aclk);
		chk_evt(5'h10);
		chk("event_stamp", st + 32'h1, event_stamp);
		test_end("second reset");
		final_report();
	end
endmodule
bind setting_group_selector group_sel_monitor mon (.aclk, .aresetn, .group_one, .group_two,
	.group_three, .group_five, .group_eight, .active_group, .group_enabled, .load_defaults,
	.event_valid);
